// ==== logic/sfrdc_top.sv ====
// Serial flash read sequencer with its two control registers and a buffered byte output.
// Assumes a 50 MHz clock, synchronous inputs and a serial clock of half the system clock.
`timescale 1ns/10ps

module sfrdc_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  // Register port.
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [7:0]        reg_rdata_out,
  // Transfer source and text fetch request.
  input  wire logic [31:0]       src_addr_in,
  input  wire logic [CNT_W-1:0]  byte_count_in,
  input  wire logic              text_fetch_req_in,
  // Read data stream.
  output logic      [7:0]        stream_data_out,
  output logic                   stream_valid_out,
  input  wire logic              stream_ready_in,
  // Status.
  output logic                   busy_out,
  output logic                   xfer_done_out,
  // Flash pins.
  output logic                   flash_chip_select_zero_n_out,
  output logic                   flash_chip_select_one_n_out,
  output logic                   flash_sck_out,
  input  wire logic              flash_serial_data_in_in,
  output logic                   flash_serial_data_out_out,
  output logic                   flash_serial_data_out_oe_n_out,
  input  wire logic              flash_serial_data_out_pin_in
);

  sfrdc_pkg::sfrdc_state_t state_reg;

  logic [7:0]       cfg_reg;
  logic [7:0]       rdata_reg;
  logic             busy_reg;
  logic             done_reg;
  logic             cs0_n_reg;
  logic             cs1_n_reg;
  logic             sck_reg;
  logic             phase_reg;
  logic             oe_n_reg;
  logic [31:0]      shift_reg;
  logic [5:0]       cnt_reg;
  logic [CNT_W-1:0] bytes_left_reg;
  logic [7:0]       rx_reg;
  logic [7:0]       byte_data_reg;
  logic             byte_valid_reg;
  logic             dual_reg;
  logic             addr32_reg;
  logic [5:0]       dummy_reg;
  logic [31:0]      addr_reg;

  logic [7:0]       op_sel;
  logic [5:0]       dummy_sel;
  logic             dual_sel;
  logic [7:0]       rx_next;
  logic             start_wr;
  logic             go;
  logic             last_bit;
  logic             stall;
  logic             byte_end;
  logic             xfer_end;

  sfrdc_stream_if #(.W(8)) buf_in_s ();
  sfrdc_stream_if #(.W(8)) buf_out_s ();

  assign buf_in_s.valid  = byte_valid_reg;
  assign buf_in_s.data   = byte_data_reg;
  assign buf_out_s.ready = stream_ready_in;

  sfrdc_two_entry_buf #(
    .W (8)
  ) u_buf (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .in_s       (buf_in_s),
    .out_s      (buf_out_s)
  );

  assign stream_data_out                = buf_out_s.data;
  assign stream_valid_out               = buf_out_s.valid;
  assign reg_rdata_out                  = rdata_reg;
  assign busy_out                       = busy_reg;
  assign xfer_done_out                  = done_reg;
  assign flash_chip_select_zero_n_out   = cs0_n_reg;
  assign flash_chip_select_one_n_out    = cs1_n_reg;
  assign flash_sck_out                  = sck_reg;
  assign flash_serial_data_out_out      = shift_reg[31];
  assign flash_serial_data_out_oe_n_out = oe_n_reg;

  // Read command decode; the dual field wins over the single-wire speed bits.
  always_comb begin
    op_sel    = sfrdc_pkg::OP_READ;
    dummy_sel = sfrdc_pkg::DUMMY_READ;
    dual_sel  = 1'b0;
    if (cfg_reg[sfrdc_pkg::CMD_DUAL_BIT]) begin
      dual_sel = 1'b1;
      if (cfg_reg[sfrdc_pkg::CMD_DIO_BIT]) begin
        op_sel    = sfrdc_pkg::OP_DUAL_IO; // R13
        dummy_sel = sfrdc_pkg::DUMMY_DUAL_IO; // R13
      end else begin
        op_sel    = sfrdc_pkg::OP_DUAL_OUT; // R12
        dummy_sel = sfrdc_pkg::DUMMY_DUAL_OUT; // R12
      end
    end else if (cfg_reg[sfrdc_pkg::CMD_FAST2_BIT]) begin
      op_sel    = sfrdc_pkg::OP_FASTEST; // R11
      dummy_sel = sfrdc_pkg::DUMMY_FASTEST; // R11
    end else if (cfg_reg[sfrdc_pkg::CMD_FAST1_BIT]) begin
      op_sel    = sfrdc_pkg::OP_FAST; // R10
      dummy_sel = sfrdc_pkg::DUMMY_FAST; // R10
    end else begin
      op_sel    = sfrdc_pkg::OP_READ; // R09
      dummy_sel = sfrdc_pkg::DUMMY_READ; // R09
    end
  end

  // Dual reads take the high bit on the data-in line and the low bit on the data-out line.
  always_comb begin
    if (dual_reg) begin
      rx_next = {rx_reg[5:0], flash_serial_data_in_in, flash_serial_data_out_pin_in}; // R12 R13
    end else begin
      rx_next = {rx_reg[6:0], flash_serial_data_in_in}; // R09 R10 R11
    end
  end

  assign start_wr = reg_wr_in & (reg_addr_in == sfrdc_pkg::REG_FLASH_DMA_START_BUSY)
                    & reg_wdata_in[sfrdc_pkg::START_BIT];
  // A start only counts in DMA mode and a text fetch only in text mode.
  assign go       = ~busy_reg & (byte_count_in != '0)
                    & ((cfg_reg[sfrdc_pkg::DMA_MODE_BIT] & start_wr)
                    | (~cfg_reg[sfrdc_pkg::DMA_MODE_BIT] & text_fetch_req_in)); // R01 R06
  assign last_bit = (cnt_reg == 6'h01);
  // The serial clock pauses between bytes while the buffer holds back the last byte.
  assign stall    = (state_reg == sfrdc_pkg::ST_DATA) & byte_valid_reg;
  assign byte_end = (state_reg == sfrdc_pkg::ST_DATA) & phase_reg & last_bit;
  // The frame closes on the last slot of the last byte, whatever the buffer is doing.
  assign xfer_end = byte_end & (bytes_left_reg == {{(CNT_W-1){1'b0}}, 1'b1});

  // Configuration register.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cfg_reg <= sfrdc_pkg::FLASH_READ_CONFIGURATION_RST;
    end else if (reg_wr_in && reg_addr_in == sfrdc_pkg::REG_FLASH_READ_CONFIGURATION) begin
      cfg_reg <= reg_wdata_in;
    end
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_reg <= sfrdc_pkg::READ_UNMAPPED;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        sfrdc_pkg::REG_FLASH_DMA_START_BUSY: begin
          rdata_reg <= {7'h00, busy_reg}; // R02
        end
        sfrdc_pkg::REG_FLASH_READ_CONFIGURATION: begin
          rdata_reg <= cfg_reg;
        end
        default: begin
          rdata_reg <= sfrdc_pkg::READ_UNMAPPED;
        end
      endcase
    end else begin
      rdata_reg <= sfrdc_pkg::READ_UNMAPPED;
    end
  end

  // Busy and done are kept apart so that status follows the frame and not the serial clock.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= xfer_end;
      if (go) begin
        busy_reg <= 1'b1; // R01 R02
      end else if (xfer_end) begin
        busy_reg <= 1'b0; // R02
      end
    end
  end

  // Chip select opens before the first opcode bit and closes with the last data slot.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cs0_n_reg <= 1'b1;
      cs1_n_reg <= 1'b1;
    end else if (go) begin
      cs0_n_reg <= cfg_reg[sfrdc_pkg::IF_SEL_BIT]; // R05 R16
      cs1_n_reg <= ~cfg_reg[sfrdc_pkg::IF_SEL_BIT]; // R05 R16
    end else if (xfer_end) begin
      cs0_n_reg <= 1'b1;
      cs1_n_reg <= 1'b1;
    end
  end

  // A finished byte waits here until the buffer takes it; the serial clock stalls meanwhile.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      byte_data_reg  <= '0;
      byte_valid_reg <= 1'b0;
    end else if (byte_end) begin
      byte_data_reg  <= rx_next; // R16
      byte_valid_reg <= 1'b1;
    end else if (byte_valid_reg && buf_in_s.ready) begin
      byte_valid_reg <= 1'b0;
    end
  end

  // Serial sequencing: chip select, opcode, address, dummy, data.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_reg      <= sfrdc_pkg::ST_IDLE;
      sck_reg        <= 1'b0;
      phase_reg      <= 1'b0;
      oe_n_reg       <= 1'b0;
      shift_reg      <= '0;
      cnt_reg        <= '0;
      bytes_left_reg <= '0;
      rx_reg         <= '0;
      dual_reg       <= 1'b0;
      addr32_reg     <= 1'b0;
      dummy_reg      <= '0;
      addr_reg       <= '0;
    end else begin
      if (state_reg == sfrdc_pkg::ST_IDLE) begin
        if (go) begin
          shift_reg      <= {op_sel, 24'h000000}; // R16
          cnt_reg        <= sfrdc_pkg::OPCODE_BITS;
          dual_reg       <= dual_sel;
          dummy_reg      <= dummy_sel;
          addr32_reg     <= cfg_reg[sfrdc_pkg::ADDR32_BIT]; // R07
          addr_reg       <= src_addr_in;
          bytes_left_reg <= byte_count_in;
          oe_n_reg       <= 1'b0;
          phase_reg      <= 1'b0;
          state_reg      <= sfrdc_pkg::ST_CMD;
        end
      end else if (!phase_reg) begin
        if (!stall) begin
          sck_reg   <= 1'b1;
          phase_reg <= 1'b1;
        end
      end else begin
        sck_reg   <= 1'b0;
        phase_reg <= 1'b0;
        shift_reg <= {shift_reg[30:0], 1'b0};
        cnt_reg   <= cnt_reg - 6'h01;
        if (state_reg == sfrdc_pkg::ST_DATA) begin
          rx_reg <= rx_next;
        end
        if (last_bit) begin
          case (state_reg)
            sfrdc_pkg::ST_CMD: begin
              if (addr32_reg) begin
                shift_reg <= addr_reg; // R07
                cnt_reg   <= sfrdc_pkg::ADDR32_BITS; // R07
              end else begin
                shift_reg <= {addr_reg[23:0], 8'h00}; // R07
                cnt_reg   <= sfrdc_pkg::ADDR24_BITS; // R07
              end
              state_reg <= sfrdc_pkg::ST_ADDR; // R16
            end
            sfrdc_pkg::ST_ADDR: begin
              shift_reg <= '0;
              oe_n_reg  <= dual_reg; // R12 R13
              if (dummy_reg == sfrdc_pkg::DUMMY_READ) begin
                cnt_reg   <= sfrdc_pkg::BYTE_SLOTS_1X; // R09
                state_reg <= sfrdc_pkg::ST_DATA; // R09
              end else begin
                cnt_reg   <= dummy_reg; // R10 R11 R12 R13
                state_reg <= sfrdc_pkg::ST_DUMMY; // R16
              end
            end
            sfrdc_pkg::ST_DUMMY: begin
              cnt_reg   <= dual_reg ? sfrdc_pkg::BYTE_SLOTS_2X : sfrdc_pkg::BYTE_SLOTS_1X;
              state_reg <= sfrdc_pkg::ST_DATA; // R16
            end
            sfrdc_pkg::ST_DATA: begin
              bytes_left_reg <= bytes_left_reg - {{(CNT_W-1){1'b0}}, 1'b1};
              cnt_reg        <= dual_reg ? sfrdc_pkg::BYTE_SLOTS_2X : sfrdc_pkg::BYTE_SLOTS_1X;
              if (xfer_end) begin
                oe_n_reg  <= 1'b0;
                state_reg <= sfrdc_pkg::ST_IDLE;
              end
            end
            default: begin
              state_reg <= sfrdc_pkg::ST_IDLE;
            end
          endcase
        end
      end
    end
  end

endmodule : sfrdc_top

// ==== logic/sfrdc_pkg.sv ====
// Constants, register map, opcodes and state encoding of the serial flash read and DMA control.
// Assumes one 50 MHz system clock and an 8-bit register port with registered read data.
//
// Summary of operation
// R01: Writing one to the start bit launches a flash DMA transfer; the bit is never stored.
// R02: Reading the start-bit position returns one while a transfer runs and zero when idle.
// R03: Software must not use text writing or send character codes while flash DMA is in use.
// R04: Software must set graphics mode and the destination canvas in display RAM before a start.
// R05: Configuration bit 7 selects flash interface 0 when clear and interface 1 when set.
// R06: Configuration bit 6 selects text mode when clear and DMA mode when set.
// R07: Configuration bit 5 sends 24 address bits when clear and 32 address bits when set.
// R08: Software must send the enter four byte address command B7h before setting bit 5.
// R09: Command field 000x issues 03h, reads the data-in line and inserts no dummy cycles.
// R10: Command field 010x issues 0Bh, reads the data-in line and inserts 8 dummy cycles.
// R11: Command field 1x0x issues 1Bh, reads the data-in line and inserts 16 dummy cycles.
// R12: Command field xx10 issues 3Bh, inserts 8 dummy cycles and reads both data lines.
// R13: Command field xx11 issues BBh, inserts 4 dummy cycles and reads both data lines.
// R14: Software must pick a read command that the attached flash supports.
// R15: Software should keep the serial clock in mode 0 or mode 3 while flash DMA is used.
// R16: Each read asserts chip select, then sends opcode, address, dummy cycles, then takes data.

package sfrdc_pkg;

  // Register port geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets and reset values.
  localparam logic [7:0] REG_FLASH_DMA_START_BUSY     = 8'hb6;
  localparam logic [7:0] REG_FLASH_READ_CONFIGURATION = 8'hb7;
  localparam logic [7:0] FLASH_DMA_START_BUSY_RST     = 8'h00;
  localparam logic [7:0] FLASH_READ_CONFIGURATION_RST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED                = 8'h00;

  // Field positions.
  localparam int START_BIT     = 0;
  localparam int IF_SEL_BIT    = 7;
  localparam int DMA_MODE_BIT  = 6;
  localparam int ADDR32_BIT    = 5;
  localparam int CMD_LSB       = 0;
  localparam int CMD_MSB       = 3;
  localparam int CMD_DUAL_BIT  = 1;
  localparam int CMD_DIO_BIT   = 0;
  localparam int CMD_FAST2_BIT = 3;
  localparam int CMD_FAST1_BIT = 2;

  // Read opcodes.
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FAST     = 8'h0b;
  localparam logic [7:0] OP_FASTEST  = 8'h1b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO  = 8'hbb;

  // Dummy serial clocks between address and data.
  localparam logic [5:0] DUMMY_READ     = 6'h00;
  localparam logic [5:0] DUMMY_FAST     = 6'h08;
  localparam logic [5:0] DUMMY_FASTEST  = 6'h10;
  localparam logic [5:0] DUMMY_DUAL_OUT = 6'h08;
  localparam logic [5:0] DUMMY_DUAL_IO  = 6'h04;

  // Serial clocks per field.
  localparam logic [5:0] OPCODE_BITS   = 6'h08;
  localparam logic [5:0] ADDR24_BITS   = 6'h18;
  localparam logic [5:0] ADDR32_BITS   = 6'h20;
  localparam logic [5:0] BYTE_SLOTS_1X = 6'h08;
  localparam logic [5:0] BYTE_SLOTS_2X = 6'h04;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA  = 3'b100
  } sfrdc_state_t;

endpackage : sfrdc_pkg

// ==== logic/sfrdc_stream_if.sv ====
// Valid and ready byte stream carried between the sequencer and its buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps

interface sfrdc_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport producer (output data, output valid, input ready);
  modport consumer (input data, input valid, output ready);
endinterface : sfrdc_stream_if

// ==== logic/sfrdc_two_entry_buf.sv ====
// Two-entry buffer with valid and ready on both sides; the head entry is the output register.
// Assumes a synchronous active-high reset and a single clock.
`timescale 1ns/10ps

module sfrdc_two_entry_buf #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic      clk_sys_in,
  input  wire logic      sys_rst_in,
  // Filling and draining sides.
  sfrdc_stream_if.consumer in_s,
  sfrdc_stream_if.producer out_s
);

  logic [W-1:0] head_reg;
  logic [W-1:0] tail_reg;
  logic         head_valid_reg;
  logic         tail_valid_reg;
  logic         push;
  logic         pop;

  // Ready depends only on a flop, so the producer never sees a combinational path.
  assign in_s.ready  = ~tail_valid_reg;
  assign out_s.valid = head_valid_reg;
  assign out_s.data  = head_reg;
  assign push        = in_s.valid & ~tail_valid_reg;
  assign pop         = head_valid_reg & out_s.ready;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      head_reg       <= '0;
      tail_reg       <= '0;
      head_valid_reg <= 1'b0;
      tail_valid_reg <= 1'b0;
    end else if (pop) begin
      if (tail_valid_reg) begin
        head_reg       <= tail_reg;
        tail_valid_reg <= 1'b0;
      end else if (push) begin
        head_reg <= in_s.data;
      end else begin
        head_valid_reg <= 1'b0;
      end
    end else if (push) begin
      if (head_valid_reg) begin
        tail_reg       <= in_s.data;
        tail_valid_reg <= 1'b1;
      end else begin
        head_reg       <= in_s.data;
        head_valid_reg <= 1'b1;
      end
    end
  end

endmodule : sfrdc_two_entry_buf

// ==== verif/sfrdc_flash_model.sv ====
// Behavioural serial flash: takes opcode and address, waits the dummy slots, returns bytes.
// Assumes mode 0 clocking and that the bench sets the address mode the host gave the flash.
`timescale 1ns/10ps
module sfrdc_flash_model (
  // Flash pins.
  input  wire logic        cs_n_in, sck_in, mosi_in, a32_in,
  output logic             miso_out, io0_out,
  // Captured command for the bench.
  output logic [7:0]       op_out,
  output logic [31:0]      adr_out
);
  int         cnt, hdr, dm, b;
  logic [7:0] v;
  initial begin
    miso_out = 1'b0;
    io0_out  = 1'b0;
    cnt      = 0;
  end
  always @(negedge cs_n_in) begin
    cnt     = 0;
    op_out  = 8'h00;
    adr_out = 32'h0;
  end
  // Released lines flip so a stale level is never mistaken for data.
  always @(posedge cs_n_in) begin
    miso_out = ~miso_out;
    io0_out  = ~io0_out;
  end
  always @(posedge sck_in) if (!cs_n_in) begin
    if (cnt < 8) op_out = {op_out[6:0], mosi_in};
    else if (cnt < 8 + (a32_in ? 32 : 24)) adr_out = {adr_out[30:0], mosi_in};
    cnt++;
  end
  // Every listed opcode is served, so any legal setting finds a partner.
  always @(negedge sck_in) if (!cs_n_in) begin
    case (op_out)
      8'h0b, 8'h3b: dm = 8;
      8'h1b:        dm = 16;
      8'hbb:        dm = 4;
      default:      dm = 0;
    endcase
    hdr = 8 + (a32_in ? 32 : 24) + dm;
    if (cnt >= hdr) begin
      b = cnt - hdr;
      if (op_out == 8'h3b || op_out == 8'hbb) begin
        v        = adr_out[7:0] + 8'(b / 4);
        miso_out = v[7 - 2 * (b % 4)];
        io0_out  = v[6 - 2 * (b % 4)];
      end else begin
        v        = adr_out[7:0] + 8'(b / 8);
        miso_out = v[7 - b % 8];
      end
    end
  end
endmodule : sfrdc_flash_model

// ==== verif/sfrdc_chk.sv ====
// Port-level checker of the flash read control.
// Assumes the single system clock and the bind at the foot.
`timescale 1ns/10ps
module sfrdc_chk #(parameter int CNT_W = 16) (
  input wire logic clk_sys_in, sys_rst_in, reg_wr_in, reg_rd_in, text_fetch_req_in,
  input wire logic stream_valid_out, stream_ready_in, busy_out, xfer_done_out,
  input wire logic flash_chip_select_zero_n_out, flash_chip_select_one_n_out,
  input wire logic flash_sck_out, flash_serial_data_in_in, flash_serial_data_out_out,
  input wire logic flash_serial_data_out_oe_n_out, flash_serial_data_out_pin_in,
  input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, stream_data_out,
  input wire logic [31:0] src_addr_in,
  input wire logic [CNT_W-1:0] byte_count_in
);
  logic [7:0] cfg_reg, op;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) cfg_reg <= 8'h00;
    else if (reg_wr_in && reg_addr_in == 8'hb7) cfg_reg <= reg_wdata_in;
  end
  always_comb op = cfg_reg[1] ? (cfg_reg[0] ? 8'hbb : 8'h3b) :
                   cfg_reg[3] ? 8'h1b : (cfg_reg[2] ? 8'h0b : 8'h03);
  sequence s_start;
    reg_wr_in && reg_addr_in == 8'hb6 && reg_wdata_in[0] && !busy_out && cfg_reg[6]
      && byte_count_in != 0;
  endsequence
  sequence s_launch;
    busy_out && flash_chip_select_zero_n_out == cfg_reg[7]
      && flash_chip_select_one_n_out == !cfg_reg[7]
      && flash_serial_data_out_out == op[7] ##1 flash_sck_out;
  endsequence
  a_start_launch: assert property (s_start |=> s_launch)
    else $error("start did not launch the selected flash");
  a_busy_read: assert property (reg_rd_in && reg_addr_in == 8'hb6
    |=> reg_rdata_out == {7'h00, $past(busy_out)}) else $error("busy readback wrong");
  a_cfg_read: assert property (reg_rd_in && reg_addr_in == 8'hb7
    |=> reg_rdata_out == $past(cfg_reg)) else $error("config readback wrong");
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_done_fall: assert property (xfer_done_out |-> $fell(busy_out))
    else $error("done without busy falling");
  a_cs_single: assert property (!(!flash_chip_select_zero_n_out
    && !flash_chip_select_one_n_out)) else $error("both chip selects low");
  a_sck_framed: assert property (flash_chip_select_zero_n_out
    && flash_chip_select_one_n_out |-> !flash_sck_out) else $error("clock outside frame");
  a_busy_selects: assert property (busy_out |-> !(flash_chip_select_zero_n_out
    && flash_chip_select_one_n_out)) else $error("busy with no chip select");
  a_stream_hold: assert property (stream_valid_out && !stream_ready_in
    |=> stream_valid_out && $stable(stream_data_out)) else $error("stalled byte lost");
endmodule : sfrdc_chk
bind sfrdc_top sfrdc_chk #(.CNT_W(CNT_W)) chk_u (.*);

// ==== verif/tb_top.sv ====
// Self-checking bench of the flash read control with a flash model on the far side.
// Assumes the register port contract: read data stand only in the cycle after the strobe.
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic        text_fetch_req_in = 1'b0, stream_ready_in = 1'b1, a32 = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, stream_data_out;
  logic [7:0]  op_seen, d;
  logic [31:0] src_addr_in = 32'h0, adr_seen;
  logic [15:0] byte_count_in = 16'h0;
  logic        stream_valid_out, busy_out, xfer_done_out, flash_chip_select_zero_n_out;
  logic        flash_chip_select_one_n_out, flash_sck_out, flash_serial_data_in_in, io0;
  logic        flash_serial_data_out_out, flash_serial_data_out_oe_n_out;
  logic        flash_serial_data_out_pin_in;
  logic [7:0]  cfgs [8] = '{8'h40, 8'h44, 8'hc8, 8'h62, 8'he3, 8'h4c, 8'h5f, 8'h84};
  int          miscompares = 0, n_checks = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  assign flash_serial_data_out_pin_in = flash_serial_data_out_oe_n_out ? io0
                                        : flash_serial_data_out_out;
  sfrdc_top #(.CNT_W(16)) dut_u (.*);
  sfrdc_flash_model flash_u (
    .cs_n_in (flash_chip_select_zero_n_out & flash_chip_select_one_n_out),
    .sck_in  (flash_sck_out),
    .mosi_in (flash_serial_data_out_pin_in),
    .a32_in  (a32),
    .miso_out(flash_serial_data_in_in),
    .io0_out (io0),
    .op_out  (op_seen),
    .adr_out (adr_seen)
  );
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    @(negedge clk_sys_in);
    d = reg_rdata_out;
  endtask : rd
  function automatic logic [7:0] opc(input logic [7:0] c);
    return c[1] ? (c[0] ? 8'hbb : 8'h3b) : c[3] ? 8'h1b : (c[2] ? 8'h0b : 8'h03);
  endfunction : opc
  // Starts that must be refused, unmapped places and the bits that are never stored.
  task refuse;
    @(posedge clk_sys_in);
    byte_count_in <= 16'h0002;
    wr(8'hb7, 8'h00);
    wr(8'hb6, 8'h01);
    rd(8'hb6); chk("text mode start", d, 8'h00);
    chk("text mode cs", {flash_chip_select_one_n_out, flash_chip_select_zero_n_out}, 2'b11);
    wr(8'hb7, 8'h40);
    text_fetch_req_in <= 1'b1;
    @(posedge clk_sys_in);
    text_fetch_req_in <= 1'b0;
    rd(8'hb6); chk("fetch in dma mode", d, 8'h00);
    byte_count_in <= 16'h0000;
    wr(8'hb6, 8'h01);
    rd(8'hb6); chk("zero count start", d, 8'h00);
    rd(8'hb5); chk("unmapped read", d, 8'h00);
    wr(8'hb5, 8'hff);
    wr(8'hb6, 8'hfe);
    rd(8'hb6); chk("start bits unstored", d, 8'h00);
    wr(8'hb7, 8'hff);
    rd(8'hb7); chk("config all ones", d, 8'hff);
  endtask : refuse
  // One transfer, begun by a start or, in text mode, by a fetch; the canvas is taken as set up.
  task xfer(input logic [7:0] c, input logic [31:0] ad, input int n, input bit stall);
    int k, i;
    bit dn, u0, u1;
    k = 0; dn = 0; u0 = 0; u1 = 0;
    a32 = c[5];
    wr(8'hb7, c);
    rd(8'hb7); chk("config", d, c);
    @(posedge clk_sys_in);
    src_addr_in   <= ad;
    byte_count_in <= 16'(n);
    if (c[6]) begin
      wr(8'hb6, 8'h01);
      wr(8'hb6, 8'h01);
    end else begin
      @(posedge clk_sys_in);
      text_fetch_req_in <= 1'b1;
      @(posedge clk_sys_in);
      text_fetch_req_in <= 1'b0;
    end
    rd(8'hb6); chk("busy", d, 8'h01);
    for (i = 0; i < 5000 && (k < n || !dn); i++) begin
      @(posedge clk_sys_in);
      if (stream_valid_out && stream_ready_in) begin
        chk("byte", stream_data_out, 8'(ad[7:0] + k));
        k++;
      end
      if (xfer_done_out === 1'b1) dn = 1;
      if (flash_chip_select_zero_n_out === 1'b0) u0 = 1;
      if (flash_chip_select_one_n_out === 1'b0) u1 = 1;
      stream_ready_in <= !(stall && i < 400);
    end
    chk("byte count", k, n);
    chk("done", dn, 1);
    chk("interface", {u1, u0}, c[7] ? 2'b10 : 2'b01);
    chk("opcode", op_seen, opc(c));
    chk("address", adr_seen, c[5] ? ad : {8'h00, ad[23:0]});
    rd(8'hb6); chk("idle", d, 8'h00);
  endtask : xfer
  initial begin
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd(8'hb6); chk("start reset", d, 8'h00);
    rd(8'hb7); chk("config reset", d, 8'h00);
    refuse();
    for (int j = 0; j < 8; j++) xfer(cfgs[j], {8'(j + 1), 16'h5a3c, 8'(j * 16)}, 2 + j % 3, j == 3);
    close_out();
  end
  // Whole run needs under two thousand cycles; this bound is ten times that.
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
endmodule : tb_top
